// ### verilog/ub_pkg.sv
// Constants, register map and state type of the serial break and control block
package ub_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_CTL0 = 10'h2ab;
  localparam logic [9:0] IDX_CTL1 = 10'h2ac;
  localparam logic [9:0] IDX_TXB  = 10'h2a0;
  localparam logic [9:0] IDX_STAT = 10'h2a1;
  localparam logic [9:0] IDX_MASK = 10'h2a2;
  localparam logic [9:0] IDX_BAUD = 10'h2a3;
  localparam logic [9:0] IDX_LIVE = 10'h2a4;
  localparam logic [9:0] IDX_BCLR = 10'h2a5;
  // ==========================================================
  // Field positions
  localparam int C0_BAUD_SPEED_SELECT  = 7;
  localparam int C0_AUTO_BAUD_ENABLE = 6;
  localparam int C0_TRANSMIT_ENABLE_BIT  = 5;
  localparam int C0_RECEIVE_ENABLE_BIT  = 4;
  localparam int C1_ON    = 7;
  localparam int C1_WUE   = 4;
  localparam int C1_BIMD  = 3;
  localparam int C1_BOVR  = 1;
  localparam int C1_SEND_BREAK = 0;
  localparam int ST_BRK   = 0;
  localparam int ST_WAKE  = 1;
  localparam int ST_TXDN  = 2;
  localparam int ST_ABD   = 3;
  // ==========================================================
  // Modes
  localparam logic [3:0] MODE_7B     = 4'h1;
  localparam logic [3:0] MODE_ODD    = 4'h2;
  localparam logic [3:0] MODE_EVEN   = 4'h3;
  localparam logic [3:0] MODE_ADDR   = 4'h4;
  localparam logic [3:0] MODE_ABDMAX = 4'h7;
  localparam logic [3:0] MODE_DMX    = 4'ha;
  localparam logic [3:0] MODE_LINMS  = 4'hc;
  // ==========================================================
  // Break and timing figures
  localparam int         BRK_ZEROS   = 12;
  localparam logic [3:0] BRK_LEN     = 4'(BRK_ZEROS + 2);
  localparam logic [13:0] BRK_FRAME  = 14'h2000;
  localparam logic [4:0] DET_ASYNC   = 5'h0b;
  localparam logic [4:0] DET_DMX     = 5'h17;
  localparam int         CPB_HI      = 4;
  localparam int         CPB_LO      = 16;
  localparam logic [3:0] PH_HI_LAST  = 4'(CPB_HI - 1);
  localparam logic [3:0] PH_LO_LAST  = 4'(CPB_LO - 1);
  localparam logic [2:0] ABD_EDGES   = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // State
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_BREAK = 2'b01,
    TX_CHAR  = 2'b10
  } ub_tx_type;

  typedef struct packed {
    logic [7:0]  ctl0;
    logic        on;
    logic        wake_up_enable;
    logic        bimd;
    logic        bovr;
    logic        send_break;
    logic [15:0] bdiv;
    logic [3:0]  mask;
    logic [3:0]  stat;
    logic [8:0]  txb;
    logic        txfull;
    ub_tx_type   st;
    logic [13:0] sh;
    logic [3:0]  cnt;
    logic [15:0] pre;
    logic [3:0]  ph;
    logic        rxp;
    logic [3:0]  rph;
    logic [4:0]  rbits;
    logic        rpend;
    logic [2:0]  abcnt;
    logic        awh;
    logic [11:0] awa;
    logic        wh;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
  } ub_state_type;

  // Every field, register reset values included, clears to zero
  localparam ub_state_type UB_STATE_RST = '0;
endpackage

// ### verilog/ub_serial_ctl.sv
// Break generation, break detection and main control of a serial port
// Operation
// - Fixed Break is start bit, twelve zero bits, then stop bit.
// - Break override forces transmit output low; otherwise shifter drives it, or high when idle.
// - Send-break plus transmit enable: buffer write sends Break, then character.
// - Hardware clears send-break after the Break stop bit completes.
// - LIN and DMX modes generate Break themselves; send-break ignored.
// - Send-break is read-only in LIN, DMX and DALI modes.
// - Shift-empty flag shows Break activity like ordinary characters.
// - Break detected after 11 low bit periods, or 23 in DMX.
// - Break flag at threshold if mode bit set, else on return high.
// - Sleep stops the port; only wake-on-break and break override still work.
// - Speed bit picks 4 baud clocks per bit, else 16.
// - Auto-baud waits for 0x55, reads zero when done, locked above 0111.
// - Transmit enabled: pin driven while active, port direction when idle.
// - Clearing enables keeps buffers; buffer-clear controls and port enable low empty them.
// - Four-bit mode field selects character format and protocol.
// - Port enable low holds the serial port in reset.
// - Wake-up: falling receive edge sets wake flag and clears wake enable.
`timescale 1ns/1ps
module ub_serial_ctl
  import ub_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial line and system
  input  wire logic        rxd,
  output logic             txd,
  output logic             tx_oe,
  input  wire logic        port_drive_en,
  input  wire logic        sleep,
  output logic             irq,
  output logic             wake
);

  // ==========================================================
  // Helpers
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == IDX_CTL0) || (idx == IDX_CTL1) ||
                (idx == IDX_TXB)  || (idx == IDX_STAT) ||
                (idx == IDX_MASK) || (idx == IDX_BAUD) ||
                (idx == IDX_LIVE) || (idx == IDX_BCLR);
  endfunction

  // Returns {length, frame} sent LSB first, padded with idle ones
  function automatic logic [17:0] frame_of(input logic [3:0] md,
                                           input logic [8:0] d);
    logic b9;
    b9 = 1'b0;
    case (md)
      MODE_7B:   frame_of = {4'h9, 5'h1f, 1'b1, d[6:0], 1'b0};
      MODE_ODD:  frame_of = {4'hb, 3'h7, 1'b1, ~^d[7:0], d[7:0], 1'b0};
      MODE_EVEN: frame_of = {4'hb, 3'h7, 1'b1, ^d[7:0], d[7:0], 1'b0};
      MODE_ADDR: frame_of = {4'hb, 3'h7, 1'b1, d[8], d[7:0], 1'b0};
      default:   frame_of = {4'ha, 4'hf, 1'b1, d[7:0], b9};
    endcase
  endfunction

  ub_state_type s;
  ub_state_type n;

  logic [3:0]  mode;
  logic        transmit_enable_bit;
  logic        receive_enable_bit;
  logic        run;
  logic        tick;
  logic [3:0]  ph_last;
  logic        auto_brk;
  logic [4:0]  brk_thr;
  logic        rx_fall;
  logic        wr_go;
  logic        rd_go;
  logic        txe;
  logic [9:0]  wr_idx;
  logic [9:0]  rd_idx;

  assign mode     = s.ctl0[3:0];
  assign transmit_enable_bit     = s.ctl0[C0_TRANSMIT_ENABLE_BIT];
  assign receive_enable_bit     = s.ctl0[C0_RECEIVE_ENABLE_BIT];
  // Sleep freezes the baud clock, so no serial timing advances
  assign run      = s.on & ~sleep;
  assign tick     = run & (s.pre == 16'h0000);
  assign ph_last  = s.ctl0[C0_BAUD_SPEED_SELECT] ? PH_HI_LAST : PH_LO_LAST;
  assign auto_brk = (mode == MODE_LINMS) || (mode == MODE_DMX);
  assign brk_thr  = (mode == MODE_DMX) ? DET_DMX : DET_ASYNC;
  assign rx_fall  = s.rxp & ~rxd;
  assign wr_go    = s.awh & s.wh & ~s.bv;
  assign rd_go    = arvalid & ~s.rv;
  assign txe      = (s.st == TX_IDLE);
  assign wr_idx   = s.awa[11:2];
  assign rd_idx   = araddr[11:2];

  // ==========================================================
  // Next state
  always_comb begin
    logic [3:0]  ev;
    logic [3:0]  clr;
    logic        ab_now;
    logic [31:0] rv_d;
    ev     = 4'h0;
    clr    = 4'h0;
    ab_now = 1'b0;
    rv_d   = 32'h0;
    n      = s;

    // Baud prescaler
    if (!run || tick) begin
      n.pre = s.bdiv;
    end else begin
      n.pre = s.pre - 16'h0001;
    end

    // Transmitter
    unique case (s.st)
      TX_IDLE: begin
        if (run && transmit_enable_bit && s.txfull) begin
          n.ph = 4'h0;
          if (auto_brk || s.send_break) begin
            n.st  = TX_BREAK;
            n.sh  = BRK_FRAME;
            n.cnt = BRK_LEN;
          end else begin
            {n.cnt, n.sh} = frame_of(mode, s.txb);
            n.st          = TX_CHAR;
            n.txfull      = 1'b0;
          end
        end
      end
      TX_BREAK, TX_CHAR: begin
        if (tick) begin
          if (s.ph == ph_last) begin
            n.ph  = 4'h0;
            n.sh  = {1'b1, s.sh[13:1]};
            n.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
              if (s.st == TX_BREAK) begin
                n.send_break       = 1'b0;
                {n.cnt, n.sh} = frame_of(mode, s.txb);
                n.txfull      = 1'b0;
                n.st          = TX_CHAR;
              end else begin
                n.st         = TX_IDLE;
                ev[ST_TXDN]  = 1'b1;
              end
            end
          end else begin
            n.ph = s.ph + 4'h1;
          end
        end
      end
      default: n.st = TX_IDLE;
    endcase

    // Break detector; any high sample restarts the run
    n.rxp = rxd;
    if (rxd || !(run && receive_enable_bit && !s.wake_up_enable)) begin
      n.rph   = 4'h0;
      n.rbits = 5'h00;
      if (rxd && s.rpend) begin
        ev[ST_BRK] = 1'b1;
        n.rpend    = 1'b0;
      end
    end else if (tick) begin
      if (s.rph == ph_last) begin
        n.rph = 4'h0;
        if (s.rbits != brk_thr) begin
          n.rbits = s.rbits + 5'h01;
        end
        if (s.rbits == brk_thr - 5'h01) begin
          if (s.bimd) begin
            ev[ST_BRK] = 1'b1;
          end else begin
            n.rpend = 1'b1;
          end
        end
      end else begin
        n.rph = s.rph + 4'h1;
      end
    end

    // Wake edge is seen even in sleep
    if (s.on && s.wake_up_enable && rx_fall) begin
      ev[ST_WAKE] = 1'b1;
      n.wake_up_enable       = 1'b0;
    end

    // Auto-baud: sync 0x55 gives five falling edges; rate capture not kept
    if (!(s.on && s.ctl0[C0_AUTO_BAUD_ENABLE])) begin
      n.abcnt = 3'h0;
    end else if (run && rx_fall) begin
      if (s.abcnt == ABD_EDGES - 3'h1) begin
        n.ctl0[C0_AUTO_BAUD_ENABLE] = 1'b0;
        ev[ST_ABD]       = 1'b1;
        n.abcnt          = 3'h0;
      end else begin
        n.abcnt = s.abcnt + 3'h1;
      end
    end

    // Register writes; software lands after the hardware clears above, but the port-off reset below lands after it
    if (awvalid && !s.awh) begin
      n.awh = 1'b1;
      n.awa = awaddr;
    end
    if (wvalid && !s.wh) begin
      n.wh = 1'b1;
      n.wd = wdata;
      n.ws = wstrb;
    end
    if (wr_go) begin
      n.awh = 1'b0;
      n.wh  = 1'b0;
      n.bv  = 1'b1;
      n.br  = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      if (s.ws[0]) begin
        case (wr_idx)
          IDX_CTL0: begin
            ab_now = n.ctl0[C0_AUTO_BAUD_ENABLE];
            n.ctl0 = s.wd[7:0];
            if (mode > MODE_ABDMAX) begin
              n.ctl0[C0_AUTO_BAUD_ENABLE] = ab_now;
            end
          end
          IDX_CTL1: begin
            n.on   = s.wd[C1_ON];
            n.wake_up_enable  = s.wd[C1_WUE];
            n.bimd = s.wd[C1_BIMD];
            n.bovr = s.wd[C1_BOVR];
            if (!mode[3]) begin
              n.send_break = s.wd[C1_SEND_BREAK];
            end
          end
          IDX_TXB: begin
            if (!s.txfull) begin
              n.txb    = s.wd[8:0];
              n.txfull = 1'b1;
            end
          end
          IDX_STAT: clr = s.wd[3:0];
          IDX_MASK: n.mask = s.wd[3:0];
          IDX_BAUD: n.bdiv[7:0] = s.wd[7:0];
          IDX_BCLR: begin
            if (s.wd[0]) begin
              n.txfull = 1'b0;
            end
            if (s.wd[1]) begin
              n.rpend = 1'b0;
              n.rbits = 5'h00;
            end
          end
          default: ;
        endcase
      end
      if (s.ws[1] && wr_idx == IDX_BAUD) begin
        n.bdiv[15:8] = s.wd[15:8];
      end
    end
    if (s.bv && bready) begin
      n.bv = 1'b0;
    end

    // Port disabled: serial logic held in reset, registers kept
    if (!s.on) begin
      n.st     = TX_IDLE;
      n.txfull = 1'b0;
      n.ph     = 4'h0;
      n.rph    = 4'h0;
      n.rbits  = 5'h00;
      n.rpend  = 1'b0;
    end

    // Set wins over a write-one clear in the same cycle
    n.stat = (s.stat & ~clr) | ev;

    // Register reads
    case (rd_idx)
      IDX_CTL0: rv_d[7:0] = s.ctl0;
      IDX_CTL1: rv_d[7:0] = {s.on, 2'b00, s.wake_up_enable, s.bimd, 1'b0, s.bovr, s.send_break};
      IDX_TXB:  rv_d[8:0] = s.txb;
      IDX_STAT: rv_d[3:0] = s.stat;
      IDX_MASK: rv_d[3:0] = s.mask;
      IDX_BAUD: rv_d[15:0] = s.bdiv;
      IDX_LIVE: rv_d[3:0] = {s.rpend, rxd, s.txfull, txe};
      default:  rv_d = 32'h0;
    endcase
    if (rd_go) begin
      n.rv = 1'b1;
      n.rd = rv_d;
      n.rr = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rv && rready) begin
      n.rv = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= UB_STATE_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign awready = ~s.awh;
  assign wready  = ~s.wh;
  assign bvalid  = s.bv;
  assign bresp   = s.br;
  assign arready = ~s.rv;
  assign rvalid  = s.rv;
  assign rdata   = s.rd;
  assign rresp   = s.rr;
  // Low is the non-idle level of the line
  assign txd     = s.bovr ? 1'b0 : (txe ? 1'b1 : s.sh[0]);
  assign tx_oe   = (transmit_enable_bit && !txe) ? 1'b1 : port_drive_en;
  assign irq     = |(s.stat & s.mask);
  assign wake    = s.stat[ST_WAKE] & s.mask[ST_WAKE];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  brk_frame_load_a: assert property ($rose(s.st == TX_BREAK) |->
      s.sh == BRK_FRAME && s.cnt == BRK_LEN) else $error("bad break frame");
  brk_override_a: assert property (s.bovr |-> !txd)
      else $error("override not forcing low");
  brk_then_char_a: assert property ($past(s.st) == TX_BREAK && s.st != TX_BREAK
      && s.on |-> s.st == TX_CHAR) else $error("no char after break");
  send_break_clear_a: assert property ($past(s.st) == TX_BREAK && s.st == TX_CHAR
      |-> !s.send_break) else $error("send-break not cleared");
  brk_cause_a: assert property ($rose(s.st == TX_BREAK) |->
      $past(auto_brk) || $past(s.send_break)) else $error("break without cause");
  send_break_ro_a: assert property ($rose(s.send_break) |-> !$past(mode[3]))
      else $error("send-break set in protocol mode");
  // Empty may only return at the end of a character stop bit, or when the port is shut
  tx_empty_a: assert property ($rose(txe) |-> !$past(s.on) ||
      ($past(s.st) == TX_CHAR && $past(s.cnt) == 4'h1))
      else $error("empty flag before stop bit end");
  brk_thr_a: assert property ($rose(s.stat[ST_BRK]) && $past(s.bimd) |->
      s.rbits == brk_thr) else $error("break flag at wrong count");
  brk_late_a: assert property ($rose(s.stat[ST_BRK]) && !$past(s.bimd) |->
      $past(rxd)) else $error("late break flag while low");
  brk_restart_a: assert property (ce && rxd |=> s.rbits == 5'h00)
      else $error("break count not restarted");
  wake_a: assert property (ce && s.on && s.wake_up_enable && rx_fall && !wr_go |=>
      !s.wake_up_enable && s.stat[ST_WAKE]) else $error("wake not taken");
  tx_drive_a: assert property (transmit_enable_bit && !txe |-> tx_oe)
      else $error("pin not driven in frame");
  port_off_a: assert property (ce && !s.on |=> s.st == TX_IDLE && !s.txfull)
      else $error("port off not reset");

  brk_char_c: cover property (s.st == TX_BREAK ##[1:1000] s.st == TX_CHAR);
  brk_rx_c: cover property ($rose(s.stat[ST_BRK]));
  wake_c: cover property ($rose(s.stat[ST_WAKE]));

endmodule // ub_serial_ctl

// ### test/ub_remote_node.sv
// Remote serial node: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
module ub_remote_node (
  // Line
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  // Idle line is Mark, so the released line reads high
  initial rxd = 1'b1;
  // ==========
  // Line stimulus and capture
  task automatic space_run(input int bits, input int bclk);
    @(posedge aclk);
    rxd <= 1'b0;
    repeat (bits * bclk) @(posedge aclk);
    rxd <= 1'b1;
  endtask
  // Waits for a start edge, samples mid-bit; no wait after the last bit, so a
  // frame that follows at once is not mistaken for this one
  task automatic recv(input int n, input int bclk, output logic [31:0] v, output bit ok);
    int t;
    v = '0;
    t = 0;
    while (txd !== 1'b0 && t < 4000) begin
      @(posedge aclk);
      t++;
    end
    ok = (t < 4000);
    repeat (bclk / 2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      v[i] = txd;
      if (i < n - 1) repeat (bclk) @(posedge aclk);
    end
  endtask
endmodule // ub_remote_node

// ### test/ub_serial_ctl_tb_top.sv
// Self-checking bench for the serial break and control block
`timescale 1ns/1ps
module ub_serial_ctl_tb_top;
  import ub_pkg::*;
  localparam int BCLK = 8;
  localparam int RB = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sleep = 1'b0;
  logic port_drive_en = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic rxd, txd, tx_oe, irq, wake;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  bit q[$];

  ub_serial_ctl uut (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rxd, .txd, .tx_oe, .port_drive_en, .sleep, .irq, .wake
  );
  ub_remote_node node (.aclk, .txd, .rxd);

  always #20 aclk = ~aclk;
  // ==========
  // Checks and bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
    samples_checked++;
    if (got !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, e);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(RESP_OKAY), "bresp");
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    chk(32'(rresp), 32'(er), "rresp");
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [31:0] e,
                      input logic [31:0] mk = 32'hffffffff);
    logic [31:0] d;
    rd(idx, d, RESP_OKAY);
    chk(d & mk, e, "register");
  endtask
  task automatic mkchar(input logic [7:0] d);
    q.push_back(1'b0);
    for (int i = 0; i < 8; i++) q.push_back(d[i]);
    q.push_back(1'b1);
  endtask
  task automatic cmpq(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) chk(32'(v[i]), 32'(q.pop_front()), "line bit");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      test_done();
    end
  end
  // ==========
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [7:0] dat;
    logic [3:0] m;
    bit ok, pde;
    logic ab;
    logic [3:0] pm;
    logic [3:0] modes[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    logic [3:0] dm[5] = '{4'h0, 4'h0, 4'h0, 4'ha, 4'ha};
    bit bi[5] = '{1, 1, 0, 1, 1};
    int bl[5] = '{10, 12, 12, 22, 24};
    bit em[5] = '{0, 1, 0, 0, 1};
    bit ee[5] = '{0, 1, 1, 0, 1};
    void'($urandom(49));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(IDX_CTL0, 32'h0);
    rchk(IDX_CTL1, 32'h0);
    rchk(IDX_LIVE, 32'h1, 32'h1);
    rd(10'h3ff, v, RESP_SLVERR);
    chk(v, 32'h0, "unmapped");
    $display("test reset done");
    // Auto-baud enable is locked by the mode in force when the write lands
    ab = 1'b0;
    pm = 4'h0;
    foreach (modes[i]) begin
      wr(IDX_CTL1, 32'h0);
      wr(IDX_CTL0, {24'h0, 1'b0, i[0], 2'b00, modes[i]});
      if (pm <= MODE_ABDMAX) ab = i[0];
      pm = modes[i];
      rchk(IDX_CTL0, {24'h0, 1'b0, ab, 2'b00, modes[i]});
      wr(IDX_CTL1, 32'h1);
      rchk(IDX_CTL1, {31'h0, !modes[i][3]});
    end
    wr(IDX_CTL1, 32'h0);
    $display("test modes done");
    wr(IDX_BAUD, 32'h1);
    wr(IDX_CTL0, 32'ha0);
    wr(IDX_CTL1, 32'h82);
    chk(32'(txd), 32'h0, "override");
    wr(IDX_CTL1, 32'h80);
    chk(32'(txd), 32'h1, "released");
    sleep <= 1'b1;
    dat = 8'($urandom);
    wr(IDX_TXB, {24'h0, dat});
    repeat (BCLK * 4) @(posedge aclk);
    chk(32'(txd), 32'h1, "asleep");
    q = {};
    mkchar(dat);
    fork
      node.recv(10, BCLK, v, ok);
      sleep <= 1'b0;
    join
    cmpq(v, 10);
    $display("test override and sleep done");
    for (int k = 0; k < 4; k++) begin
      m = (k < 2) ? 4'h0 : ((k == 2) ? MODE_LINMS : MODE_DMX);
      dat = 8'($urandom);
      pde = 1'($urandom);
      port_drive_en <= pde;
      wr(IDX_CTL1, 32'h0);
      wr(IDX_CTL0, {24'h0, 4'ha, m});
      wr(IDX_CTL1, (k == 1) ? 32'h81 : 32'h80);
      q = {};
      if (k > 0) begin
        repeat (13) q.push_back(1'b0);
        q.push_back(1'b1);
      end
      mkchar(dat);
      fork
        begin
          if (k > 0) begin
            node.recv(14, BCLK, v, ok);
            cmpq(v, 14);
          end
          node.recv(10, BCLK, v, ok);
          cmpq(v, 10);
          chk(32'(ok), 32'h1, "start seen");
        end
        begin
          wr(IDX_TXB, {24'h0, dat});
          repeat (BCLK * 3) @(posedge aclk);
          chk(32'(tx_oe), 32'h1, "drive");
          rchk(IDX_LIVE, 32'h0, 32'h1);
          if (k == 1) rchk(IDX_CTL1, 32'h1, 32'h1);
        end
      join
      repeat (BCLK * 2) @(posedge aclk);
      chk(32'(tx_oe), 32'(pde), "idle drive");
      rchk(IDX_LIVE, 32'h1, 32'h1);
      rchk(IDX_CTL1, 32'h0, 32'h1);
    end
    $display("test break send done");
    for (int k = 1; k < 5; k++) begin
      dat = 8'($urandom);
      wr(IDX_CTL1, 32'h0);
      wr(IDX_CTL0, {24'h0, 4'ha, 4'(k)});
      wr(IDX_CTL1, 32'h80);
      q = {};
      q.push_back(1'b0);
      for (int i = 0; i < 8; i++) if (k > 1 || i < 7) q.push_back(dat[i]);
      if (k == 2) q.push_back(~^dat);
      if (k == 3) q.push_back(^dat);
      // Ninth bit written as one marks an address character
      if (k == 4) q.push_back(1'b1);
      q.push_back(1'b1);
      fork
        node.recv((k == 1) ? 9 : 11, BCLK, v, ok);
        wr(IDX_TXB, {23'h0, 1'b1, dat});
      join
      cmpq(v, (k == 1) ? 9 : 11);
      chk(32'(ok), 32'h1, "format start");
    end
    $display("test char formats done");
    wr(IDX_CTL1, 32'h0);
    wr(IDX_CTL0, 32'h0);
    wr(IDX_CTL1, 32'h80);
    wr(IDX_TXB, 32'h5a);
    rchk(IDX_LIVE, 32'h2, 32'h2);
    wr(IDX_BCLR, 32'h1);
    rchk(IDX_LIVE, 32'h0, 32'h2);
    wr(IDX_TXB, 32'h5a);
    wr(IDX_CTL1, 32'h0);
    rchk(IDX_LIVE, 32'h0, 32'h2);
    $display("test buffer done");
    wr(IDX_BAUD, 32'h0);
    foreach (bl[i]) begin
      wr(IDX_CTL1, 32'h0);
      wr(IDX_CTL0, {24'h0, 4'h1, dm[i]});
      wr(IDX_CTL1, {24'h0, 4'h8, bi[i], 3'h0});
      fork
        node.space_run(bl[i], RB);
        begin
          repeat ((bl[i] - 1) * RB + RB / 2) @(posedge aclk);
          rchk(IDX_STAT, 32'(em[i]), 32'h1);
        end
      join
      repeat (RB * 2) @(posedge aclk);
      rchk(IDX_STAT, 32'(ee[i]), 32'h1);
      wr(IDX_STAT, 32'h1);
    end
    node.space_run(12, RB);
    repeat (RB) @(posedge aclk);
    node.space_run(12, RB);
    repeat (RB * 2) @(posedge aclk);
    rchk(IDX_STAT, 32'h0, 32'h1);
    $display("test break detect done");
    wr(IDX_CTL1, 32'h0);
    wr(IDX_CTL0, 32'h0);
    wr(IDX_CTL0, 32'h40);
    wr(IDX_CTL1, 32'h80);
    repeat (4) node.space_run(1, RB);
    rchk(IDX_CTL0, 32'h40, 32'h40);
    node.space_run(1, RB);
    rchk(IDX_CTL0, 32'h0, 32'h40);
    rchk(IDX_STAT, 32'h8, 32'h8);
    $display("test auto-baud done");
    wr(IDX_CTL1, 32'h90);
    node.space_run(1, RB);
    rchk(IDX_STAT, 32'h2, 32'h2);
    rchk(IDX_CTL1, 32'h0, 32'h10);
    chk(32'(irq), 32'h0, "masked");
    wr(IDX_MASK, 32'h2);
    chk(32'(irq), 32'h1, "irq");
    chk(32'(wake), 32'h1, "wake");
    wr(IDX_STAT, 32'h2);
    chk(32'(irq), 32'h0, "cleared");
    $display("test wake done");
    test_done();
  end
endmodule // ub_serial_ctl_tb_top
